// ---- rtl/dsau_pkg.sv ----
// Package for the data-space access unit: constants, codes and carrier structs.
// Assumes a 16-bit core with byte addressing and a 24-bit extended data space.
package dsau_pkg;
  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int DSAU_AW = 16;
  localparam int DSAU_XW = 24;
  localparam int DSAU_RPW = 10;
  localparam int DSAU_WPW = 9;
  localparam int DSAU_NM = 3;
  // ----------------------------------------------------------------
  // Address map and reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] DSAU_LOW_LIMIT = 16'h2FFF;
  localparam logic [15:0] DSAU_NEAR_MASK = 16'h1FFF;
  localparam int DSAU_EA_HI_BIT = 15;
  localparam int DSAU_RP_PROG_BIT = 9;
  localparam logic [9:0] DSAU_RPAG_RST = 10'h001;
  localparam logic [8:0] DSAU_WPAG_RST = 9'h001;
  localparam logic [15:0] DSAU_SP_RST = 16'h1000;
  // ----------------------------------------------------------------
  // Master priority encodings
  // ----------------------------------------------------------------
  localparam logic [15:0] DSAU_PRI_DEF = 16'h0000;
  localparam logic [15:0] DSAU_PRI_CPU1 = 16'h0008;
  localparam logic [15:0] DSAU_PRI_DMA0 = 16'h0020;
  localparam logic [15:0] DSAU_PRI_DMA1 = 16'h0028;
  // Master indices
  localparam int DSAU_M_CPU = 0;
  localparam int DSAU_M_DMA = 1;
  localparam int DSAU_M_DBG = 2;

  typedef enum logic [2:0] {
    DSAU_AM_IND, DSAU_AM_POST, DSAU_AM_PRE, DSAU_AM_IDX, DSAU_AM_LIT
  } dsau_amode_t;

  typedef enum logic [1:0] {
    DSAU_ST_NONE, DSAU_ST_PUSH, DSAU_ST_POP
  } dsau_stop_t;

  typedef enum logic [1:0] {
    DSAU_PC_CALL, DSAU_PC_EXC
  } dsau_pckind_t;

  typedef struct packed {
    logic [15:0] base;
    logic [15:0] offset;
    logic [15:0] modv;
    dsau_amode_t mode;
  } dsau_eareq_t;

  typedef struct packed {
    logic valid;
    logic wr;
    logic [15:0] ea;
  } dsau_acc_t;
endpackage : dsau_pkg

// ---- rtl/dsau_ea_gen.sv ----
// Effective address generator for one operand.
// Assumes inputs are stable in the cycle of use; purely combinational.
`timescale 1ns/1ps
module dsau_ea_gen
  import dsau_pkg::*;
(
  input wire dsau_eareq_t req,
  output logic [15:0] ea,
  output logic [15:0] base_new
);
  always_comb
  begin
    ea = req.base;
    base_new = req.base;
    unique case (req.mode)
      DSAU_AM_IND: ea = req.base;
      DSAU_AM_POST:
      begin
        ea = req.base;
        base_new = req.base + req.modv;
      end
      DSAU_AM_PRE:
      begin
        ea = req.base + req.modv;
        base_new = req.base + req.modv;
      end
      DSAU_AM_IDX: ea = req.base + req.offset;
      DSAU_AM_LIT: ea = req.base + req.modv;
      default:
      begin
        ea = req.base;
        base_new = req.base;
      end
    endcase
  end
endmodule : dsau_ea_gen

// ---- rtl/dsau_xlate.sv ----
// Translates a 16-bit base address with a page value into an extended address.
// Assumes the page value is already the register selected for the direction.
`timescale 1ns/1ps
module dsau_xlate
  import dsau_pkg::*;
(
  input wire logic [15:0] ea,
  input wire logic [8:0] page,
  output logic [23:0] xaddr,
  output logic addr_err
);
  always_comb
  begin
    if (ea[DSAU_EA_HI_BIT])
    begin
      xaddr = {page, ea[14:0]};
      addr_err = (page == 9'h000);
    end
    else
    begin
      xaddr = {8'h00, ea};
      addr_err = 1'b0;
    end
  end
endmodule : dsau_xlate

// ---- rtl/dsau_top.sv ----
// Data-space access unit: paging, arbitration, stack pointer and operand addressing.
// Assumes masters hold their requests until granted and memory answers in one cycle.
//
// Notes on behaviour
// - Base addresses up to 0x2FFF are always reachable as page 0.
// - Upper-half access with zero page raises an address error.
// - Both page registers reset to 0x001.
// - Writing zero to a page register leaves it unchanged.
// - Non-zero pages only through base addresses with bit 15 set.
// - Each non-zero value of page bits 8:0 maps the upper half to its own 32-Kbyte window.
// - Arbiter grants the highest priority master; others wait.
// - Default order: CPU, then DMA, then debugger.
// - Priority codes 0x0020 and 0x0028 put DMA above the CPU; 0x0008 keeps the default order.
// - Masters above or below the CPU keep their relative order.
// - Stack pointer bit 0 is always zero.
// - Stack pointer resets to 0x1000.
// - Push writes then increments; pop decrements then reads.
// - PC push: low word first, then bits 22:16 (zero-extended on calls).
// - Exception push puts status low byte in second word.
// - Stack and active frame pointer are never paged.
// - Direct operands use a 13-bit address field.
// - Effective address from base, modifier, offset or literal.
// - First arithmetic operand is a working register directly.
// - Move source and destination share one offset-register field.
// - Dual prefetch uses registers 8-9 for X, 10-11 for Y.
// - Dual prefetch index only on 9 and 11; steps 2, 4, 6.
// - Page bits appended above address bits 14:0 give 24 bits.
// - Read page is 10 bits, write page is 9 bits.
`timescale 1ns/1ps
module dsau_top
  import dsau_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  // Page and priority control writes
  input wire logic rpag_we,
  input wire logic [9:0] rpag_wdata,
  input wire logic wpag_we,
  input wire logic [8:0] wpag_wdata,
  input wire logic pri_we,
  input wire logic [15:0] pri_wdata,
  output logic [9:0] read_page_reg,
  output logic [8:0] write_page_reg,
  output logic [15:0] master_priority_ctrl,
  // Master requests: index 0 CPU, 1 DMA, 2 debugger
  input wire dsau_acc_t [2:0] mreq,
  output logic [2:0] mgrant,
  output logic [2:0] mstall,
  // Memory side
  output logic mem_valid,
  output logic mem_wr,
  output logic [23:0] mem_addr,
  output logic mem_addr_err,
  // Stack
  input wire dsau_stop_t st_op,
  input wire dsau_pckind_t pc_kind,
  input wire logic pc_push,
  input wire logic [22:0] pc_value,
  input wire logic [15:0] cpu_status_word,
  input wire logic sp_we,
  input wire logic [15:0] sp_wdata,
  output logic [15:0] stack_pointer_reg,
  output logic st_valid,
  output logic st_wr,
  output logic [15:0] st_addr,
  output logic [15:0] st_wdata,
  // Frame pointer limit
  input wire logic frame_pointer_active,
  input wire logic [15:0] frame_pointer_reg,
  output logic [15:0] fp_addr,
  // Operand addressing
  input wire dsau_eareq_t ea_src,
  input wire dsau_eareq_t ea_dst,
  input wire logic [3:0] offset_reg_sel,
  input wire logic [12:0] file_addr,
  output logic [15:0] src_ea,
  output logic [15:0] dst_ea,
  output logic [15:0] src_base_new,
  output logic [15:0] dst_base_new,
  output logic [3:0] shared_offset_sel,
  output logic [15:0] file_ea,
  // Arithmetic operand 2 select
  input wire logic [1:0] op2_kind,
  input wire logic [15:0] op1_default_working_reg,
  input wire logic [15:0] op2_default_working_reg,
  input wire logic [15:0] op2_mem,
  input wire logic [4:0] op2_lit,
  output logic [15:0] alu_op1,
  output logic [15:0] alu_op2,
  // Dual prefetch
  input wire logic [3:0] x_reg_sel,
  input wire logic [3:0] y_reg_sel,
  input wire logic [1:0] x_mode,
  input wire logic [1:0] y_mode,
  input wire logic [15:0] x_base,
  input wire logic [15:0] y_base,
  input wire logic [15:0] x_off,
  input wire logic [15:0] y_off,
  output logic [15:0] x_ea,
  output logic [15:0] y_ea,
  output logic [15:0] x_base_new,
  output logic [15:0] y_base_new,
  output logic dual_illegal
);
  // ----------------------------------------------------------------
  // Page and priority registers
  // ----------------------------------------------------------------
  logic [9:0] rpag_r, rpag_nxt;
  logic [8:0] wpag_r, wpag_nxt;
  logic [15:0] pri_r, pri_nxt;

  always_comb
  begin
    rpag_nxt = rpag_r;
    wpag_nxt = wpag_r;
    pri_nxt = pri_r;
    if (rpag_we && rpag_wdata != 10'h000)
      rpag_nxt = rpag_wdata;
    if (wpag_we && wpag_wdata != 9'h000)
      wpag_nxt = wpag_wdata;
    // Reserved codes are dropped so the arbiter order stays defined
    if (pri_we && (pri_wdata == DSAU_PRI_DEF || pri_wdata == DSAU_PRI_CPU1 ||
                   pri_wdata == DSAU_PRI_DMA0 || pri_wdata == DSAU_PRI_DMA1))
      pri_nxt = pri_wdata;
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rpag_r <= DSAU_RPAG_RST;
      wpag_r <= DSAU_WPAG_RST;
      pri_r <= DSAU_PRI_DEF;
    end
    else
    begin
      rpag_r <= rpag_nxt;
      wpag_r <= wpag_nxt;
      pri_r <= pri_nxt;
    end
  end

  assign read_page_reg = rpag_r;
  assign write_page_reg = wpag_r;
  assign master_priority_ctrl = pri_r;

  // ----------------------------------------------------------------
  // Arbiter
  // ----------------------------------------------------------------
  logic dma_first;
  logic [2:0] gnt_c;
  logic [2:0] live_c;
  logic [2:0] gnt_r, stall_r;
  dsau_acc_t win_c;

  // Only DMA can be raised above the CPU; the debugger is always last
  assign dma_first = (pri_r == DSAU_PRI_DMA0) || (pri_r == DSAU_PRI_DMA1);

  always_comb
  begin
    // A master granted last cycle still shows its request until it sees the grant;
    // it sits out one round, otherwise every access would be served twice
    for (int i = 0; i < DSAU_NM; i++)
      live_c[i] = mreq[i].valid & ~gnt_r[i];
    gnt_c = 3'h0;
    if (dma_first && live_c[DSAU_M_DMA])
      gnt_c[DSAU_M_DMA] = 1'b1;
    else if (live_c[DSAU_M_CPU])
      gnt_c[DSAU_M_CPU] = 1'b1;
    else if (live_c[DSAU_M_DMA])
      gnt_c[DSAU_M_DMA] = 1'b1;
    else if (live_c[DSAU_M_DBG])
      gnt_c[DSAU_M_DBG] = 1'b1;
    win_c = '0;
    for (int i = 0; i < DSAU_NM; i++)
      if (gnt_c[i])
        win_c = mreq[i];
  end

  logic [23:0] xaddr_c;
  logic xerr_c;
  dsau_xlate u_xlate (
    .ea(win_c.ea),
    .page(win_c.wr ? wpag_r : rpag_r[8:0]),
    .xaddr(xaddr_c),
    .addr_err(xerr_c)
  );

  logic mem_valid_r, mem_wr_r, mem_err_r;
  logic [23:0] mem_addr_r;

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      gnt_r <= 3'h0;
      stall_r <= 3'h0;
      mem_valid_r <= 1'b0;
      mem_wr_r <= 1'b0;
      mem_addr_r <= 24'h000000;
      mem_err_r <= 1'b0;
    end
    else
    begin
      gnt_r <= gnt_c;
      for (int i = 0; i < DSAU_NM; i++)
        stall_r[i] <= live_c[i] & ~gnt_c[i];
      mem_valid_r <= (|gnt_c) & ~xerr_c;
      mem_wr_r <= win_c.wr;
      mem_addr_r <= xaddr_c;
      mem_err_r <= (|gnt_c) & xerr_c;
    end
  end

  assign mgrant = gnt_r;
  assign mstall = stall_r;
  assign mem_valid = mem_valid_r;
  assign mem_wr = mem_wr_r;
  assign mem_addr = mem_addr_r;
  assign mem_addr_err = mem_err_r;

  // ----------------------------------------------------------------
  // Software stack
  // ----------------------------------------------------------------
  logic [15:0] sp_r, sp_nxt;
  logic pc_hi_r, pc_hi_nxt;
  logic [15:0] pc_word2_r, pc_word2_nxt;
  logic stv_r, stv_nxt, stw_r, stw_nxt;
  logic [15:0] sta_r, sta_nxt, std_r, std_nxt;

  always_comb
  begin
    sp_nxt = sp_r;
    pc_hi_nxt = 1'b0;
    pc_word2_nxt = pc_word2_r;
    stv_nxt = 1'b0;
    stw_nxt = 1'b0;
    sta_nxt = sta_r;
    std_nxt = std_r;
    if (pc_hi_r)
    begin
      stv_nxt = 1'b1;
      stw_nxt = 1'b1;
      sta_nxt = sp_r;
      std_nxt = pc_word2_r;
      sp_nxt = sp_r + 16'h0002;
    end
    else if (pc_push)
    begin
      stv_nxt = 1'b1;
      stw_nxt = 1'b1;
      sta_nxt = sp_r;
      std_nxt = pc_value[15:0];
      sp_nxt = sp_r + 16'h0002;
      pc_hi_nxt = 1'b1;
      if (pc_kind == DSAU_PC_EXC)
        pc_word2_nxt = {cpu_status_word[7:0], 1'b0, pc_value[22:16]};
      else
        pc_word2_nxt = {9'h000, pc_value[22:16]};
    end
    else if (st_op == DSAU_ST_PUSH)
    begin
      stv_nxt = 1'b1;
      stw_nxt = 1'b1;
      sta_nxt = sp_r;
      std_nxt = sp_wdata;
      sp_nxt = sp_r + 16'h0002;
    end
    else if (st_op == DSAU_ST_POP)
    begin
      stv_nxt = 1'b1;
      sta_nxt = sp_r - 16'h0002;
      sp_nxt = sp_r - 16'h0002;
    end
    else if (sp_we)
      sp_nxt = sp_wdata;
    sp_nxt[0] = 1'b0;
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sp_r <= DSAU_SP_RST;
      pc_hi_r <= 1'b0;
      pc_word2_r <= 16'h0000;
      stv_r <= 1'b0;
      stw_r <= 1'b0;
      sta_r <= 16'h0000;
      std_r <= 16'h0000;
    end
    else
    begin
      sp_r <= sp_nxt;
      pc_hi_r <= pc_hi_nxt;
      pc_word2_r <= pc_word2_nxt;
      stv_r <= stv_nxt;
      stw_r <= stw_nxt;
      sta_r <= sta_nxt;
      std_r <= std_nxt;
    end
  end

  // Stack and frame addresses stay 16 bits: never paged
  assign stack_pointer_reg = sp_r;
  assign st_valid = stv_r;
  assign st_wr = stw_r;
  assign st_addr = sta_r;
  assign st_wdata = std_r;

  // ----------------------------------------------------------------
  // Operand addressing (registered outputs)
  // ----------------------------------------------------------------
  logic [15:0] s_ea_c, d_ea_c, s_bn_c, d_bn_c;
  dsau_ea_gen u_src (.req(ea_src), .ea(s_ea_c), .base_new(s_bn_c));
  dsau_ea_gen u_dst (.req(ea_dst), .ea(d_ea_c), .base_new(d_bn_c));

  logic [15:0] alu2_c;
  logic [15:0] xea_c, yea_c, xbn_c, ybn_c;
  logic [15:0] xstep, ystep;
  logic dual_bad_c;

  always_comb
  begin
    unique case (op2_kind)
      2'h0: alu2_c = op2_default_working_reg;
      2'h1: alu2_c = op2_mem;
      default: alu2_c = {11'h000, op2_lit};
    endcase
    // Modes: 0 indirect, 1 post +2/4/6 by reg bits, 3 indexed
    xstep = 16'h0002 + {13'h0000, x_off[1:0], 1'b0};
    ystep = 16'h0002 + {13'h0000, y_off[1:0], 1'b0};
    xea_c = (x_mode == 2'h3) ? x_base + x_off : x_base;
    yea_c = (y_mode == 2'h3) ? y_base + y_off : y_base;
    xbn_c = (x_mode == 2'h1) ? x_base + xstep : x_base;
    ybn_c = (y_mode == 2'h1) ? y_base + ystep : y_base;
    dual_bad_c = (x_reg_sel != 4'h8 && x_reg_sel != 4'h9) ||
                 (y_reg_sel != 4'hA && y_reg_sel != 4'hB) ||
                 (x_mode == 2'h3 && x_reg_sel != 4'h9) ||
                 (y_mode == 2'h3 && y_reg_sel != 4'hB) ||
                 (x_mode == 2'h1 && x_off[1:0] == 2'h3) ||
                 (y_mode == 2'h1 && y_off[1:0] == 2'h3) || (x_mode == 2'h2) || (y_mode == 2'h2);
  end

  logic [15:0] sea_r, dea_r, sbn_r, dbn_r, fea_r, fp_r, a1_r, a2_r;
  logic [15:0] xea_r, yea_r, xbn_r, ybn_r;
  logic [3:0] osel_r;
  logic dbad_r;

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sea_r <= 16'h0000;
      dea_r <= 16'h0000;
      sbn_r <= 16'h0000;
      dbn_r <= 16'h0000;
      fea_r <= 16'h0000;
      fp_r <= 16'h0000;
      a1_r <= 16'h0000;
      a2_r <= 16'h0000;
      xea_r <= 16'h0000;
      yea_r <= 16'h0000;
      xbn_r <= 16'h0000;
      ybn_r <= 16'h0000;
      osel_r <= 4'h0;
      dbad_r <= 1'b0;
    end
    else
    begin
      sea_r <= s_ea_c;
      dea_r <= d_ea_c;
      sbn_r <= s_bn_c;
      dbn_r <= d_bn_c;
      osel_r <= offset_reg_sel;
      fea_r <= {3'h0, file_addr} & DSAU_NEAR_MASK;
      // Active frame pointer is clamped to 16 bits, never paged
      fp_r <= frame_pointer_active ? frame_pointer_reg : 16'h0000;
      a1_r <= op1_default_working_reg;
      a2_r <= alu2_c;
      xea_r <= xea_c;
      yea_r <= yea_c;
      xbn_r <= xbn_c;
      ybn_r <= ybn_c;
      dbad_r <= dual_bad_c;
    end
  end

  assign src_ea = sea_r;
  assign dst_ea = dea_r;
  assign src_base_new = sbn_r;
  assign dst_base_new = dbn_r;
  assign shared_offset_sel = osel_r;
  assign file_ea = fea_r;
  assign fp_addr = fp_r;
  assign alu_op1 = a1_r;
  assign alu_op2 = a2_r;
  assign x_ea = xea_r;
  assign y_ea = yea_r;
  assign x_base_new = xbn_r;
  assign y_base_new = ybn_r;
  assign dual_illegal = dbad_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_sp_align;
    @(posedge clock) disable iff (!rst_b) stack_pointer_reg[0] == 1'b0;
  endproperty
  a_sp_align: assert property (p_sp_align) else $error("stack pointer misaligned");

  property p_page_zero_kept;
    @(posedge clock) disable iff (!rst_b) (rpag_we && rpag_wdata == 10'h000) |=> $stable(read_page_reg);
  endproperty
  a_page_zero_kept: assert property (p_page_zero_kept) else $error("zero write changed read page");

  property p_err_on_zero_page;
    @(posedge clock) disable iff (!rst_b)
      (|gnt_c && win_c.ea[15] && (win_c.wr ? wpag_r == 9'h000 : rpag_r[8:0] == 9'h000))
        |=> (mem_addr_err && !mem_valid);
  endproperty
  a_err_on_zero_page: assert property (p_err_on_zero_page) else $error("page zero access not trapped");

  property p_low_direct;
    @(posedge clock) disable iff (!rst_b)
      (|gnt_c && win_c.ea <= DSAU_LOW_LIMIT) |=> (mem_valid && mem_addr == {8'h00, $past(win_c.ea)});
  endproperty
  a_low_direct: assert property (p_low_direct) else $error("low base address not direct");

  property p_cpu_over_dbg;
    @(posedge clock) disable iff (!rst_b)
      (live_c[DSAU_M_CPU] && live_c[DSAU_M_DBG]) |=> (!mgrant[DSAU_M_DBG] && mstall[DSAU_M_DBG]);
  endproperty
  a_cpu_over_dbg: assert property (p_cpu_over_dbg) else $error("debugger beat cpu");

  property p_dma_raised;
    @(posedge clock) disable iff (!rst_b)
      (dma_first && live_c[DSAU_M_DMA] && live_c[DSAU_M_CPU]) |=> (mgrant[DSAU_M_DMA] && mstall[DSAU_M_CPU]);
  endproperty
  a_dma_raised: assert property (p_dma_raised) else $error("raised dma not granted");

  property p_one_grant;
    @(posedge clock) disable iff (!rst_b) $onehot0(mgrant);
  endproperty
  a_one_grant: assert property (p_one_grant) else $error("multiple grants");

  property p_push_inc;
    @(posedge clock) disable iff (!rst_b)
      (st_op == DSAU_ST_PUSH && !pc_push && !pc_hi_r) |=> (st_addr == $past(sp_r) && sp_r == $past(sp_r) + 16'h0002);
  endproperty
  a_push_inc: assert property (p_push_inc) else $error("push order wrong");

  property p_pc_second_word;
    @(posedge clock) disable iff (!rst_b)
      (pc_push && !pc_hi_r && pc_kind == DSAU_PC_CALL) |=> ##1 (st_wr && st_wdata[15:7] == 9'h000);
  endproperty
  a_pc_second_word: assert property (p_pc_second_word) else $error("call upper word not zero-extended");
endmodule : dsau_top

// ---- tb/dsau_master_model.sv ----
// Bus master model: raises one data request on command and keeps it until granted.
// Assumes the grant is sampled on the rising edge after the one at which the arbiter raises it.
`timescale 1ns/1ps
module dsau_master_model
  import dsau_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic go,
  input wire logic wr,
  input wire logic [15:0] ea,
  input wire logic grant,
  output dsau_acc_t req
);
  always @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      req <= '0;
    else if (go)
      req <= '{1'b1, wr, ea};
    else if (req.valid && grant)
      // Released fields change, so a stale address can never pass for a live one
      req <= '{1'b0, ~req.wr, ~req.ea};
  end
endmodule : dsau_master_model

// ---- tb/dsau_top_tb.sv ----
// Self-checking bench for the data-space access unit.
// Assumes every output answers one cycle after its request.
`timescale 1ns/1ps
module dsau_top_tb
  import dsau_pkg::*;
;
  logic clock = 0, rst_b = 0, rpag_we = 0, wpag_we = 0, pri_we = 0, pc_push = 0, sp_we = 0;
  logic m_wr = 0, frame_pointer_active = 0, mem_valid, mem_wr, mem_addr_err, st_valid, st_wr;
  logic dual_illegal;
  logic [2:0] mgrant, mstall, go = '0;
  logic [9:0] rpag_wdata = '0, read_page_reg;
  logic [8:0] wpag_wdata = '0, write_page_reg;
  logic [3:0] offset_reg_sel = '0, x_reg_sel = '0, y_reg_sel = '0, shared_offset_sel;
  logic [1:0] op2_kind = '0, x_mode = '0, y_mode = '0;
  logic [4:0] op2_lit = 5'h1F;
  logic [12:0] file_addr = '0;
  logic [22:0] pc_value = 23'h5ABCDE;
  logic [23:0] mem_addr;
  logic [15:0] pri_wdata = '0, cpu_status_word = 16'h12C3, sp_wdata = '0, frame_pointer_reg = '0;
  logic [15:0] m_ea = '0, op1_default_working_reg = 16'h1111, op2_default_working_reg = 16'h2222, op2_mem = 16'h3333;
  logic [15:0] x_base = 16'h0800, y_base = 16'h0C00, x_off = '0, y_off = 16'h0020;
  logic [15:0] master_priority_ctrl, stack_pointer_reg, st_addr, st_wdata, fp_addr, file_ea;
  logic [15:0] src_ea, dst_ea, src_base_new, dst_base_new, alu_op1, alu_op2;
  logic [15:0] x_ea, y_ea, x_base_new, y_base_new;
  dsau_stop_t st_op = DSAU_ST_NONE;
  dsau_pckind_t pc_kind = DSAU_PC_CALL;
  dsau_eareq_t ea_src = '0, ea_dst = '0;
  wire dsau_acc_t [2:0] mreq;
  int miscompares = 0, checked = 0;

  initial forever #5 clock = ~clock;

  for (genvar i = 0; i < 3; i++)
  begin : g_master
    dsau_master_model u_m (.clock(clock), .rst_b(rst_b), .go(go[i]), .wr(m_wr), .ea(m_ea),
      .grant(mgrant[i]), .req(mreq[i]));
  end

  dsau_top dut (.*);

  // --------------------------------------------------------------
  // Shared helpers
  // --------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(negedge clock);
  endtask : tick

  task automatic close_out();
    $display("checked %0d, miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : close_out

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic bound(input int n, input int lim);
    if (n >= lim)
    begin
      miscompares++;
      $display("wrong value at %0t: wait ran out", $time);
      close_out();
    end
  endtask : bound

  task automatic set_pg(input logic [9:0] r, input logic [8:0] w);
    rpag_wdata = r;
    wpag_wdata = w;
    rpag_we = 1;
    wpag_we = 1;
    tick(1);
    rpag_we = 0;
    wpag_we = 0;
    tick(1);
  endtask : set_pg

  task automatic set_pri(input logic [15:0] d);
    pri_wdata = d;
    pri_we = 1;
    tick(1);
    pri_we = 0;
    tick(1);
  endtask : set_pri

  // CPU access alone; the grant cycle also carries the memory request
  task automatic mem_acc(input logic wr, input logic [15:0] ea, input logic [23:0] exp, input logic err = 1'b0);
    int n = 0;
    m_wr = wr;
    m_ea = ea;
    go = 3'b001;
    tick(1);
    go = 3'b000;
    while (mgrant[0] !== 1'b1 && n < 8)
    begin
      tick(1);
      n++;
    end
    bound(n, 8);
    chk({mem_valid, mem_wr, mem_addr_err}, {~err, wr, err});
    chk(mem_addr, exp);
    tick(2);
  endtask : mem_acc

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic t_pages();
    chk(read_page_reg, 10'h001);
    chk(write_page_reg, 9'h001);
    chk(stack_pointer_reg, 16'h1000);
    chk(master_priority_ctrl, 16'h0000);
    set_pg(10'h000, 9'h002);
    chk(read_page_reg, 10'h001);
    set_pg(10'h201, 9'h000);
    chk({read_page_reg, write_page_reg}, {10'h201, 9'h002});
    set_pri(16'h0010);
    chk(master_priority_ctrl, 16'h0000);
    set_pg(10'h003, 9'h000);
    mem_acc(1, 16'h8000, 24'h010000);
    mem_acc(1, 16'hFFFE, 24'h017FFE);
    mem_acc(0, 16'h8002, 24'h018002);
    mem_acc(0, 16'h2FFF, 24'h002FFF);
    // Read page bits 8:0 are zero here, so an upper-half read must trap
    set_pg(10'h200, 9'h001);
    mem_acc(0, 16'h8004, 24'h000004, 1'b1);
    set_pg(10'h001, 9'h001);
    mem_acc(0, 16'hFFFF, 24'h00FFFF);
    mem_acc(1, 16'h7FFE, 24'h007FFE);
  endtask : t_pages

  task automatic t_arb();
    logic [15:0] code [4] = '{16'h0000, 16'h0008, 16'h0020, 16'h0028};
    logic [2:0] first, last;
    int n;
    for (int k = 0; k < 4; k++)
    begin
      set_pri(code[k]);
      chk(master_priority_ctrl, code[k]);
      m_ea = 16'h0100;
      go = 3'b111;
      tick(1);
      go = 3'b000;
      tick(1);
      first = mgrant;
      chk(first, k < 2 ? 3'b001 : 3'b010);
      chk(mstall, 3'b111 & ~first);
      n = 0;
      last = first;
      while ((mreq[0].valid | mreq[1].valid | mreq[2].valid) === 1'b1 && n < 16)
      begin
        if (mgrant !== 3'b000)
          last = mgrant;
        tick(1);
        n++;
      end
      bound(n, 16);
      chk(last, 3'b100);
      tick(2);
    end
  endtask : t_arb

  task automatic t_stack();
    st_op = DSAU_ST_PUSH;
    sp_wdata = 16'hA55A;
    tick(1);
    st_op = DSAU_ST_POP;
    chk({st_valid, st_wr, st_addr, st_wdata}, {2'b11, 16'h1000, 16'hA55A});
    chk(stack_pointer_reg, 16'h1002);
    tick(1);
    st_op = DSAU_ST_NONE;
    chk({st_valid, st_wr, st_addr, stack_pointer_reg}, {2'b10, 16'h1000, 16'h1000});
    for (int k = 0; k < 2; k++)
    begin
      pc_kind = k == 0 ? DSAU_PC_CALL : DSAU_PC_EXC;
      pc_push = 1;
      tick(1);
      pc_push = 0;
      chk({st_addr, st_wdata}, {16'h1000 + 16'(4 * k), 16'hBCDE});
      tick(1);
      chk({st_valid, st_wr, st_addr}, {2'b11, 16'h1002 + 16'(4 * k)});
      chk(st_wdata, k == 0 ? 16'h005A : 16'hC35A);
      chk(stack_pointer_reg, 16'h1004 + 16'(4 * k));
    end
    sp_we = 1;
    sp_wdata = 16'h2345;
    tick(1);
    sp_we = 0;
    chk(stack_pointer_reg, 16'h2344);
    frame_pointer_reg = 16'hFFFE;
    frame_pointer_active = 1;
    tick(1);
    chk(fp_addr, 16'hFFFE);
    frame_pointer_active = 0;
    tick(1);
    chk(fp_addr, 16'h0000);
  endtask : t_stack

  task automatic t_ea();
    dsau_amode_t md [5] = '{DSAU_AM_IND, DSAU_AM_POST, DSAU_AM_PRE, DSAU_AM_IDX, DSAU_AM_LIT};
    logic [15:0] ea_x [5] = '{16'h1000, 16'h1000, 16'h1010, 16'h1010, 16'h1010};
    logic [15:0] nb_x [5] = '{16'h1000, 16'h1010, 16'h1010, 16'h1000, 16'h1000};
    for (int k = 0; k < 5; k++)
    begin
      ea_src = '{16'h1000, 16'h0010, 16'h0010, md[k]};
      ea_dst = '{16'h2000, 16'h0010, 16'h0010, md[4 - k]};
      offset_reg_sel = 4'(k);
      file_addr = 13'h1FFF - 13'(k);
      op2_kind = 2'(k);
      tick(1);
      chk({src_ea, src_base_new}, {ea_x[k], nb_x[k]});
      chk(dst_ea, ea_x[4 - k] + 16'h1000);
      chk(dst_base_new, nb_x[4 - k] + 16'h1000);
      chk(shared_offset_sel, 4'(k));
      chk(file_ea, 16'h1FFF - 16'(k));
      chk(alu_op1, 16'h1111);
      chk(alu_op2, k % 4 == 0 ? 16'h2222 : k == 1 ? 16'h3333 : 16'h001F);
    end
  endtask : t_ea

  task automatic t_dual();
    logic [3:0] xs [5] = '{4'h8, 4'h9, 4'hA, 4'h9, 4'h8};
    logic [3:0] ys [5] = '{4'hB, 4'hB, 4'hB, 4'h8, 4'hA};
    logic [1:0] xm [5] = '{2'h3, 2'h3, 2'h0, 2'h0, 2'h0};
    logic ill [5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
    x_reg_sel = 4'h8;
    y_reg_sel = 4'hB;
    y_mode = 2'h3;
    x_mode = 2'h1;
    for (int k = 0; k < 4; k++)
    begin
      x_off = 16'(k);
      tick(1);
      chk(dual_illegal, k == 3);
      chk({y_ea, y_base_new}, {16'h0C20, 16'h0C00});
      if (k < 3)
        chk({x_ea, x_base_new}, {16'h0800, 16'h0802 + 16'(2 * k)});
    end
    y_mode = 2'h0;
    x_off = 16'h0040;
    for (int k = 0; k < 5; k++)
    begin
      x_reg_sel = xs[k];
      y_reg_sel = ys[k];
      x_mode = xm[k];
      tick(1);
      chk(dual_illegal, ill[k]);
      if (k == 1)
        chk(x_ea, 16'h0840);
    end
    // Mode 2 has no meaning for dual prefetch
    x_reg_sel = 4'h9;
    y_reg_sel = 4'hB;
    x_mode = 2'h2;
    tick(1);
    chk(dual_illegal, 1'b1);
  endtask : t_dual

  initial
  begin
    tick(8);
    rst_b = 1;
    t_pages();
    t_arb();
    t_stack();
    t_ea();
    t_dual();
    close_out();
  end
endmodule : dsau_top_tb
